// file: design/isr_pkg.sv
// Purpose: Shared constants and types for the indirect store and return executor.
// Assumes: One instruction is offered per cycle by the decode stage.
// Notes: What this block does is listed below.
// What this block does
// - Indirect store writes accumulator to address held in selected pointer; flags untouched.
// - Two-bit mode: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Pre modes address pointer plus/minus one; post modes use old pointer, then adjust.
// - Relative form addresses pointer plus signed offset -32..31; pointer stays.
// - Pointers span 0000h to FFFFh and wrap modulo 16 bits.
// - Pointer increment or decrement never changes any status flag.
// - No-operation is one word, one cycle, and changes nothing.
// - Option load copies accumulator into option register, no flag change.
// - Software reset requests device reset and clears the reset-instruction flag.
// - Return from interrupt pops stack into PC, sets enable bit 7; two cycles.
// - Return from subroutine pops stack into PC over two cycles; enables untouched.
package isr_pkg;

  // ------------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------------
  localparam int PTR_W = 16;
  localparam int DATA_W = 8;
  localparam int OFS_W = 6;
  localparam int NUM_PTR = 2;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] PTR_ONE = 16'h0001;
  localparam int GIE_BIT = 7;
  localparam int NOP_CYCLES = 1;
  localparam int RET_CYCLES = 2;

  // ------------------------------------------------------------------
  // Operation and mode codes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ISR_OP_NOP = 3'h0,
    ISR_OP_STORE_MODE = 3'h1,
    ISR_OP_STORE_REL = 3'h2,
    ISR_OP_OPTION_LD = 3'h3,
    ISR_OP_SW_RESET = 3'h4,
    ISR_OP_RET_IRQ = 3'h5,
    ISR_OP_RET_SUB = 3'h6
  } isr_op_e;

  typedef enum logic [1:0] {
    ISR_MODE_PRE_INC = 2'h0,
    ISR_MODE_PRE_DEC = 2'h1,
    ISR_MODE_POST_INC = 2'h2,
    ISR_MODE_POST_DEC = 2'h3
  } isr_mode_e;

  typedef enum logic [1:0] {
    ISR_RET_IDLE = 2'b00,
    ISR_RET_POP = 2'b01,
    ISR_RET_FILL = 2'b10
  } isr_ret_state_e;

endpackage : isr_pkg

// file: design/isr_addr_gen.sv
// Purpose: Effective address and next pointer value for the indirect store.
// Assumes: Pure combinational; the caller registers the results.
// Notes: All arithmetic is 16 bits so carries fall off the top.
`timescale 1ns/1ps
module isr_addr_gen (
  input wire logic [15:0] ptr_in,
  input wire logic [1:0] mode_in,
  input wire logic rel_in,
  input wire logic [5:0] offset_in,
  output logic [15:0] addr_out,
  output logic [15:0] ptr_next_out
);

  // ------------------------------------------------------------------
  // Address and update selection
  // ------------------------------------------------------------------
  logic [15:0] inc_v;
  logic [15:0] dec_v;
  logic [15:0] ofs_v;

  // Wrap is free: the sum is cut back to 16 bits on purpose
  assign inc_v = 16'(ptr_in + isr_pkg::PTR_ONE);
  assign dec_v = 16'(ptr_in - isr_pkg::PTR_ONE);
  assign ofs_v = 16'(ptr_in + {{10{offset_in[5]}}, offset_in});

  // Mode decides whether the move sees the old or adjusted pointer
  always_comb begin
    addr_out = ptr_in;
    ptr_next_out = ptr_in;
    if (rel_in) begin
      addr_out = ofs_v;
    end else begin
      case (isr_pkg::isr_mode_e'(mode_in))
        isr_pkg::ISR_MODE_PRE_INC: begin
          addr_out = inc_v;
          ptr_next_out = inc_v;
        end
        isr_pkg::ISR_MODE_PRE_DEC: begin
          addr_out = dec_v;
          ptr_next_out = dec_v;
        end
        isr_pkg::ISR_MODE_POST_INC: begin
          ptr_next_out = inc_v;
        end
        default: begin
          ptr_next_out = dec_v;
        end
      endcase
    end
  end

endmodule : isr_addr_gen

// file: design/isr_ret_seq.sv
// Purpose: Two-cycle sequencer for the stack returns.
// Assumes: start_in is only raised while busy_out is low.
// Notes: The second cycle is a dead slot while fetch refills.
`timescale 1ns/1ps
module isr_ret_seq (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  output logic pop_out,
  output logic busy_out
);

  // ------------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------------
  isr_pkg::isr_ret_state_e state_r;
  isr_pkg::isr_ret_state_e state_nxt;
  logic pop_nxt;
  logic busy_nxt;

  // Pop in the first slot, then hold busy through the refill slot
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      isr_pkg::ISR_RET_IDLE: begin
        if (start_in) begin
          state_nxt = isr_pkg::ISR_RET_POP;
        end
      end
      isr_pkg::ISR_RET_POP: begin
        state_nxt = isr_pkg::ISR_RET_FILL;
      end
      default: begin
        state_nxt = isr_pkg::ISR_RET_IDLE;
      end
    endcase
    pop_nxt = (state_nxt == isr_pkg::ISR_RET_POP);
    busy_nxt = (state_nxt != isr_pkg::ISR_RET_IDLE);
  end

  // Registers only
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_r <= isr_pkg::ISR_RET_IDLE;
      pop_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pop_out <= pop_nxt;
      busy_out <= busy_nxt;
    end
  end

endmodule : isr_ret_seq

// file: design/isr_exec.sv
// Purpose: Executes indirect store, no-op, option load, soft reset and returns.
// Assumes: Decode presents one operation with op_valid_in; inputs are synchronous.
// Notes: Pointer registers live here; memory, stack and PC are outside.
`timescale 1ns/1ps
module isr_exec (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic op_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic [1:0] pointer_update_mode_in,
  input wire logic ptr_sel_in,
  input wire logic [5:0] offset_in,
  input wire logic [7:0] acc_in,
  input wire logic [15:0] stack_top_entry_in,
  input wire logic ptr_wr_in,
  input wire logic ptr_wr_sel_in,
  input wire logic [15:0] ptr_wr_data_in,
  input wire logic gie_clear_in,
  input wire logic ri_flag_set_in,
  output logic op_ready_out,
  output logic mem_we_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_data_out,
  output logic [15:0] pointer_register0_out,
  output logic [15:0] pointer_register1_out,
  output logic [7:0] option_reg_out,
  output logic dev_reset_out,
  output logic reset_instruction_flag_n_out,
  output logic global_irq_enable_out,
  output logic stack_pop_out,
  output logic pc_load_out,
  output logic [15:0] pc_out
);

  // ------------------------------------------------------------------
  // Decode of the offered operation
  // ------------------------------------------------------------------
  logic busy;
  logic take;
  logic is_store;
  logic is_rel;
  logic is_ret;
  logic [15:0] sel_ptr;
  logic [15:0] eff_addr;
  logic [15:0] ptr_upd;
  isr_pkg::isr_op_e op;

  assign op = isr_pkg::isr_op_e'(op_code_in);
  // A return in flight blocks new operations until its refill slot ends
  assign take = op_valid_in && !busy;
  assign is_rel = (op == isr_pkg::ISR_OP_STORE_REL);
  assign is_store = take && ((op == isr_pkg::ISR_OP_STORE_MODE) || is_rel);
  assign is_ret = take && ((op == isr_pkg::ISR_OP_RET_IRQ) || (op == isr_pkg::ISR_OP_RET_SUB));
  assign sel_ptr = ptr_sel_in ? pointer_register1_out : pointer_register0_out;

  isr_addr_gen u_addr (
    .ptr_in(sel_ptr),
    .mode_in(pointer_update_mode_in),
    .rel_in(is_rel),
    .offset_in(offset_in),
    .addr_out(eff_addr),
    .ptr_next_out(ptr_upd)
  );

  isr_ret_seq u_ret (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .start_in(is_ret),
    .pop_out(stack_pop_out),
    .busy_out(busy)
  );

  // ------------------------------------------------------------------
  // Pointer registers
  // ------------------------------------------------------------------
  logic [15:0] ptr_r [isr_pkg::NUM_PTR];
  logic [15:0] ptr_nxt [isr_pkg::NUM_PTR];

  genvar gi;
  generate
    for (gi = 0; gi < isr_pkg::NUM_PTR; gi++) begin : g_ptr
      // Store update wins over a software write in the same cycle
      always_comb begin
        ptr_nxt[gi] = ptr_r[gi];
        if (ptr_wr_in && (ptr_wr_sel_in == 1'(gi))) begin
          ptr_nxt[gi] = ptr_wr_data_in;
        end
        if (is_store && (ptr_sel_in == 1'(gi))) begin
          ptr_nxt[gi] = ptr_upd;
        end
      end

      always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
          ptr_r[gi] <= isr_pkg::PTR_RST;
        end else begin
          ptr_r[gi] <= ptr_nxt[gi];
        end
      end
    end
  endgenerate

  assign pointer_register0_out = ptr_r[0];
  assign pointer_register1_out = ptr_r[1];

  // ------------------------------------------------------------------
  // Store port, option, flags and return outputs
  // ------------------------------------------------------------------
  logic mem_we_nxt;
  logic [15:0] mem_addr_nxt;
  logic [7:0] mem_data_nxt;
  logic [7:0] option_nxt;
  logic dev_reset_nxt;
  logic ri_n_nxt;
  logic gie_nxt;
  logic pc_load_nxt;
  logic [15:0] pc_nxt;
  logic ready_nxt;

  // No status flag output exists: none of these operations touches flags
  always_comb begin
    mem_we_nxt = 1'b0;
    mem_addr_nxt = mem_addr_out;
    mem_data_nxt = mem_data_out;
    option_nxt = option_reg_out;
    dev_reset_nxt = 1'b0;
    ri_n_nxt = reset_instruction_flag_n_out;
    gie_nxt = global_irq_enable_out;
    pc_load_nxt = 1'b0;
    pc_nxt = pc_out;
    if (gie_clear_in) begin
      gie_nxt = 1'b0;
    end
    if (ri_flag_set_in) begin
      ri_n_nxt = 1'b1;
    end
    if (take) begin
      case (op)
        isr_pkg::ISR_OP_STORE_MODE, isr_pkg::ISR_OP_STORE_REL: begin
          mem_we_nxt = 1'b1;
          mem_addr_nxt = eff_addr;
          mem_data_nxt = acc_in;
        end
        isr_pkg::ISR_OP_OPTION_LD: begin
          option_nxt = acc_in;
        end
        isr_pkg::ISR_OP_SW_RESET: begin
          dev_reset_nxt = 1'b1;
          ri_n_nxt = 1'b0; // Instruction wins over a set request
        end
        isr_pkg::ISR_OP_RET_IRQ: begin
          pc_load_nxt = 1'b1;
          pc_nxt = stack_top_entry_in;
          gie_nxt = 1'b1; // Return re-enable wins over a clear
        end
        isr_pkg::ISR_OP_RET_SUB: begin
          pc_load_nxt = 1'b1;
          pc_nxt = stack_top_entry_in;
        end
        default: begin
          mem_we_nxt = 1'b0;
        end
      endcase
    end
    ready_nxt = !(is_ret || (busy && stack_pop_out));
  end

  // Register stage for every block output except the pointer registers and stack_pop_out
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mem_we_out <= 1'b0;
      mem_addr_out <= isr_pkg::PTR_RST;
      mem_data_out <= 8'h00;
      option_reg_out <= isr_pkg::OPTION_RST;
      dev_reset_out <= 1'b0;
      reset_instruction_flag_n_out <= 1'b1;
      global_irq_enable_out <= 1'b0;
      pc_load_out <= 1'b0;
      pc_out <= isr_pkg::PC_RST;
      op_ready_out <= 1'b1;
    end else begin
      mem_we_out <= mem_we_nxt;
      mem_addr_out <= mem_addr_nxt;
      mem_data_out <= mem_data_nxt;
      option_reg_out <= option_nxt;
      dev_reset_out <= dev_reset_nxt;
      reset_instruction_flag_n_out <= ri_n_nxt;
      global_irq_enable_out <= gie_nxt;
      pc_load_out <= pc_load_nxt;
      pc_out <= pc_nxt;
      op_ready_out <= ready_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_store_writes_acc: assert property (
      is_store |=> mem_we_out && mem_data_out == $past(acc_in))
    else $error("store did not write accumulator");
  a_pre_inc_addr: assert property (
      is_store && !is_rel && pointer_update_mode_in == 2'h0
      |=> mem_addr_out == 16'($past(sel_ptr) + 16'h0001))
    else $error("pre-increment address wrong");
  a_post_dec_ptr: assert property (
      is_store && !is_rel && pointer_update_mode_in == 2'h3
      |=> mem_addr_out == $past(sel_ptr) && 16'(mem_addr_out - 16'h0001) ==
        (($past(ptr_sel_in)) ? pointer_register1_out : pointer_register0_out))
    else $error("post-decrement update wrong");
  a_rel_keeps_ptr: assert property (
      is_store && is_rel && !ptr_wr_in
      |=> $stable(pointer_register0_out) && $stable(pointer_register1_out))
    else $error("relative store moved a pointer");
  a_ptr_wraps: assert property (
      is_store && !is_rel && !ptr_sel_in &&
      pointer_update_mode_in == 2'h2 && pointer_register0_out == 16'hFFFF
      |=> pointer_register0_out == 16'h0000)
    else $error("pointer did not wrap");
  a_other_ptr_idle: assert property (
      is_store && !ptr_wr_in && ptr_sel_in
      |=> $stable(pointer_register0_out))
    else $error("unselected pointer changed");
  a_nop_quiet: assert property (
      take && op == isr_pkg::ISR_OP_NOP && !gie_clear_in
      && !ptr_wr_in && !ri_flag_set_in |=> !mem_we_out && !pc_load_out && !dev_reset_out
      && $stable(option_reg_out) && $stable(global_irq_enable_out))
    else $error("no-op changed state");
  a_option_load: assert property (
      take && op == isr_pkg::ISR_OP_OPTION_LD
      |=> option_reg_out == $past(acc_in))
    else $error("option not loaded");
  a_soft_reset: assert property (
      take && op == isr_pkg::ISR_OP_SW_RESET
      |=> dev_reset_out && !reset_instruction_flag_n_out)
    else $error("soft reset incomplete");
  a_retirq_seq: assert property (
      take && op == isr_pkg::ISR_OP_RET_IRQ
      |=> pc_load_out && stack_pop_out && global_irq_enable_out
        && pc_out == $past(stack_top_entry_in) ##1 !op_ready_out ##1 op_ready_out)
    else $error("interrupt return sequence wrong");
  a_retsub_gie: assert property (
      take && op == isr_pkg::ISR_OP_RET_SUB && !gie_clear_in
      |=> stack_pop_out && pc_load_out && $stable(global_irq_enable_out) ##1 !pc_load_out)
    else $error("subroutine return wrong");
  a_store_one_cycle: assert property (
      is_store |-> op_ready_out ##1 op_ready_out)
    else $error("store stalled the core");

  c_store_pre: cover property (is_store && !is_rel);
  c_store_rel: cover property (is_store && is_rel && offset_in[5]);
  c_ret_irq: cover property (take && op == isr_pkg::ISR_OP_RET_IRQ);
  c_ret_back: cover property (stack_pop_out ##2 is_ret);

endmodule : isr_exec

// file: testbench/isr_exec_bench.sv
// Purpose: Self-checking bench for the indirect store and return executor.
// Assumes: Inputs change 1 ns after the rising edge; results land one edge later.
// Notes: Ordinary stores run back to back from a table; returns and resets by hand.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp); \
  end \
end
module isr_exec_bench;
  typedef struct packed {
    logic [2:0] op;
    logic [1:0] mode;
    logic sel;
    logic [5:0] ofs;
    logic [7:0] acc;
    logic we;
    logic [15:0] addr;
    logic [15:0] p0;
    logic [15:0] p1;
    logic [7:0] opt;
  } isr_row_s;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [1:0] mode = 2'h0;
  logic ptr_sel = 1'b0;
  logic [5:0] offset = 6'h00;
  logic [7:0] acc = 8'h00;
  logic [15:0] stack_top_entry = 16'h0000;
  logic ptr_wr = 1'b0;
  logic ptr_wr_sel = 1'b0;
  logic [15:0] ptr_wr_data = 16'h0000;
  logic gie_clear = 1'b0;
  logic ri_set = 1'b0;
  logic ready, we, dev_reset, ri_n, global_irq_enable, pop, pc_load;
  logic [15:0] addr, p0, p1, pc;
  logic [7:0] data, opt;
  int mismatches = 0;
  int checks_done = 0;
  isr_row_s rows [10];

  isr_exec u_dut (
    .mclk_in(mclk), .rst_n_in(rst_n), .op_valid_in(op_valid), .op_code_in(op_code),
    .pointer_update_mode_in(mode), .ptr_sel_in(ptr_sel), .offset_in(offset),
    .acc_in(acc), .stack_top_entry_in(stack_top_entry), .ptr_wr_in(ptr_wr),
    .ptr_wr_sel_in(ptr_wr_sel), .ptr_wr_data_in(ptr_wr_data), .gie_clear_in(gie_clear),
    .ri_flag_set_in(ri_set), .op_ready_out(ready), .mem_we_out(we), .mem_addr_out(addr),
    .mem_data_out(data), .pointer_register0_out(p0), .pointer_register1_out(p1),
    .option_reg_out(opt), .dev_reset_out(dev_reset),
    .reset_instruction_flag_n_out(ri_n), .global_irq_enable_out(global_irq_enable),
    .stack_pop_out(pop), .pc_load_out(pc_load), .pc_out(pc)
  );

  // Free-running 125 MHz clock
  initial begin
    forever #4 mclk = ~mclk;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step

  task automatic give_verdict();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Bounded wait so a stuck busy flag ends the run instead of hanging it
  task automatic wait_ready();
    for (int n = 0; n < 4 && ready !== 1'b1; n++) step();
    if (ready !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask : wait_ready

  task automatic chk_reset();
    `CHK(p0, isr_pkg::PTR_RST)
    `CHK(p1, isr_pkg::PTR_RST)
    `CHK(opt, isr_pkg::OPTION_RST)
    `CHK(ri_n, 1'b1)
    `CHK(global_irq_enable, 1'b0)
    `CHK(we, 1'b0)
    `CHK(pc, isr_pkg::PC_RST)
    `CHK(ready, 1'b1)
  endtask : chk_reset

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    // Pointer 1 starts at the top so both wrap directions are hit
    rows = '{
      '{3'h1, 2'h0, 1'b0, 6'h00, 8'hA5, 1'b1, 16'h0011, 16'h0011, 16'hFFFF, 8'hFF},
      '{3'h1, 2'h1, 1'b0, 6'h00, 8'h5A, 1'b1, 16'h0010, 16'h0010, 16'hFFFF, 8'hFF},
      '{3'h1, 2'h2, 1'b1, 6'h00, 8'h3C, 1'b1, 16'hFFFF, 16'h0010, 16'h0000, 8'hFF},
      '{3'h1, 2'h3, 1'b1, 6'h00, 8'hC3, 1'b1, 16'h0000, 16'h0010, 16'hFFFF, 8'hFF},
      '{3'h1, 2'h0, 1'b1, 6'h00, 8'h81, 1'b1, 16'h0000, 16'h0010, 16'h0000, 8'hFF},
      '{3'h2, 2'h3, 1'b0, 6'h20, 8'h11, 1'b1, 16'hFFF0, 16'h0010, 16'h0000, 8'hFF},
      '{3'h2, 2'h0, 1'b0, 6'h1F, 8'h22, 1'b1, 16'h002F, 16'h0010, 16'h0000, 8'hFF},
      '{3'h2, 2'h0, 1'b1, 6'h00, 8'h33, 1'b1, 16'h0000, 16'h0010, 16'h0000, 8'hFF},
      '{3'h0, 2'h0, 1'b0, 6'h00, 8'h44, 1'b0, 16'h0000, 16'h0010, 16'h0000, 8'hFF},
      '{3'h3, 2'h0, 1'b0, 6'h00, 8'h4F, 1'b0, 16'h0000, 16'h0010, 16'h0000, 8'h4F}
    };
    repeat (3) @(posedge mclk);
    #1;
    chk_reset();
    rst_n = 1'b1;
    ptr_wr = 1'b1;
    ptr_wr_data = 16'h0010;
    step();
    ptr_wr_sel = 1'b1;
    ptr_wr_data = 16'hFFFF;
    step();
    ptr_wr = 1'b0;
    // Table rows are offered on consecutive edges with valid held high
    for (int i = 0; i < 10; i++) begin
      op_valid = 1'b1;
      op_code = rows[i].op;
      mode = rows[i].mode;
      ptr_sel = rows[i].sel;
      offset = rows[i].ofs;
      acc = rows[i].acc;
      step();
      `CHK(we, rows[i].we)
      if (rows[i].we) `CHK(data, rows[i].acc)
      `CHK(addr, rows[i].addr)
      `CHK(p0, rows[i].p0)
      `CHK(p1, rows[i].p1)
      `CHK(opt, rows[i].opt)
    end
    // Return from interrupt, then a store offered through the busy slots
    gie_clear = 1'b1;
    op_code = 3'h0;
    step();
    gie_clear = 1'b0;
    `CHK(global_irq_enable, 1'b0)
    op_code = 3'h5;
    stack_top_entry = 16'h1234;
    step();
    `CHK({pop, pc_load, global_irq_enable, ready}, 4'hE)
    `CHK(pc, 16'h1234)
    op_code = 3'h1;
    mode = 2'h0;
    ptr_sel = 1'b0;
    acc = 8'h77;
    step();
    `CHK({we, pop, pc_load, ready}, 4'h0)
    `CHK(p0, 16'h0010)
    step();
    `CHK({we, ready}, 2'h1)
    step();
    `CHK({we, data}, 9'h177)
    `CHK({addr, p0}, 32'h00110011)
    // Return from subroutine keeps the enable cleared by a same-cycle gie_clear
    gie_clear = 1'b1;
    op_code = 3'h6;
    stack_top_entry = 16'h4321;
    step();
    gie_clear = 1'b0;
    op_valid = 1'b0;
    `CHK({pop, pc_load, global_irq_enable, ready}, 4'hC)
    `CHK(pc, 16'h4321)
    step();
    `CHK({pop, ready}, 2'h0)
    wait_ready();
    // Soft reset beats a same-cycle flag set
    ri_set = 1'b1;
    op_valid = 1'b1;
    op_code = 3'h4;
    step();
    ri_set = 1'b0;
    op_code = 3'h0;
    `CHK({dev_reset, ri_n}, 2'h2)
    step();
    `CHK({dev_reset, ri_n}, 2'h0)
    ri_set = 1'b1;
    step();
    ri_set = 1'b0;
    `CHK(ri_n, 1'b1)
    // Mid-run reset restores every state register
    rst_n = 1'b0;
    step();
    chk_reset();
    rst_n = 1'b1;
    // A store offered at the first edge after release must be taken at once
    op_code = 3'h1;
    mode = 2'h2;
    ptr_sel = 1'b0;
    acc = 8'h5C;
    step();
    `CHK({we, ready, data}, 10'h35C)
    `CHK({addr, p0}, 32'h00000001)
    op_valid = 1'b0;
    step();
    `CHK({we, ready}, 2'h1)
    give_verdict();
  end
endmodule : isr_exec_bench
